// File: srap_port.sv
// Serial register access port: link logic, write FIFO and register bank
`timescale 1ns/10ps
`default_nettype none

module srap_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clock, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [WIDTH-1:0] inData, // Word to store
  input wire logic inValid, // Word offered
  output logic inReady, // Room for a word
  output logic [WIDTH-1:0] outData, // Oldest word
  output logic outValid, // Word available
  input wire logic outReady // Consumer takes word
);
  localparam int PW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // srap_fifo

module srap_port #(
  parameter int DEPTH = srap_pkg::FIFO_DEPTH
) (
  input wire logic clock, // System clock, 40 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic serialClock, // Host serial clock
  input wire logic selectN, // Follower select, active low
  input wire logic dataIn, // Serial data from host
  output logic dataOut, // Serial data to host
  output logic dataOutOe, // High while data output driven
  input wire logic interface_select_strap, // High: serial port mode
  input wire logic address_strap_low, // Two-wire address bit 0
  input wire logic address_strap_high, // Two-wire address bit 1
  output srap_pkg::srap_bank_t regs, // Register contents
  output logic chipEnable, // Device active, not standby
  output srap_pkg::srap_strap_t strapState // Captured strap levels
);
  import srap_pkg::*;

  // ---------------- System domain: straps ----------------
  logic [2:0] strapMeta_q;
  logic [2:0] strapSync_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strapMeta_q <= '0;
      strapSync_q <= '0;
      strapState <= '0;
    end else begin
      strapMeta_q <= {interface_select_strap, address_strap_high, address_strap_low};
      strapSync_q <= strapMeta_q;
      strapState.spiMode <= strapSync_q[2];
      strapState.followerAddrLow <= strapSync_q[1:0];
    end
  end

  // ---------------- Link domain ----------------
  logic linkRst_n;
  logic [2:0] bitCnt_q;
  srap_phase_t byteIdx_q;
  logic [6:0] shift_q;
  logic [ADDR_W-1:0] addr_q;
  logic isWrite_q;
  logic readActive_q;
  logic [7:0] txByte_q;
  logic [7:0] rxByte;
  logic byteDone;
  logic [1:0] modeMeta_q;
  logic wrReq_q;
  srap_wr_word_t wrWord_q;
  srap_bank_t linkBank_q;
  logic snapMeta_q;
  logic snapSync_q;
  logic snapSeen_q;
  logic snapAck_q;
  logic linkChipEn;

  // Select high holds link logic in reset
  assign linkRst_n = reset_n && !selectN;
  // Bytes assembled most significant bit first
  assign rxByte = {shift_q, dataIn};
  assign byteDone = (bitCnt_q == 3'h7);
  assign linkChipEn = linkBank_q[OFS_DEVICE_ENABLE[2:0]][POS_CHIP_EN];

  function automatic logic [7:0] bankRead(input srap_bank_t bank, input logic [ADDR_W-1:0] a, input logic en);
    logic [7:0] r;
    r = '0;
    // Standby exposes only the enable register
    if (a < ADDR_W'(NUM_REGS) && (en || a == OFS_DEVICE_ENABLE)) begin
      r = bank[a[2:0]];
    end
    return r;
  endfunction

  // Strap mode level into the link domain
  always_ff @(posedge serialClock or negedge reset_n) begin
    if (!reset_n) begin
      modeMeta_q <= '0;
    end else begin
      modeMeta_q <= {modeMeta_q[0], strapState.spiMode};
    end
  end

  always_ff @(posedge serialClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      bitCnt_q <= '0;
      byteIdx_q <= PH_ADDR_HIGH;
      shift_q <= '0;
      addr_q <= '0;
      isWrite_q <= 1'b0;
      readActive_q <= 1'b0;
      txByte_q <= '0;
    end else if (modeMeta_q[1]) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shift_q <= rxByte[6:0];
      if (byteDone) begin
        case (byteIdx_q)
          PH_ADDR_HIGH: begin
            addr_q[9:2] <= rxByte;
            byteIdx_q <= PH_ADDR_LOW;
          end
          PH_ADDR_LOW: begin
            addr_q[1:0] <= {rxByte[POS_ADDR_LOW_HI], rxByte[POS_ADDR_LOW_LO]};
            isWrite_q <= rxByte[POS_DIR];
            // Read drives output from here on
            readActive_q <= !rxByte[POS_DIR];
            // First read byte ready for next eight clocks
            txByte_q <= bankRead(linkBank_q, {addr_q[9:2], rxByte[POS_ADDR_LOW_HI], rxByte[POS_ADDR_LOW_LO]},
                                 linkChipEn);
            byteIdx_q <= PH_DATA;
          end
          default: begin
            addr_q <= addr_q + 1'b1;
            txByte_q <= bankRead(linkBank_q, addr_q + 1'b1, linkChipEn);
          end
        endcase
      end
    end
  end

  // Write word held stable for the system domain; not cleared by select
  always_ff @(posedge serialClock or negedge reset_n) begin
    if (!reset_n) begin
      wrReq_q <= 1'b0;
      wrWord_q <= '0;
    end else if (modeMeta_q[1] && !selectN && byteDone && byteIdx_q == PH_DATA && isWrite_q) begin
      wrWord_q <= '{addr: addr_q, data: rxByte};
      wrReq_q <= !wrReq_q;
    end
  end

  always_ff @(negedge serialClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      dataOut <= 1'b0;
      dataOutOe <= 1'b0;
    end else begin
      dataOutOe <= readActive_q;
      dataOut <= readActive_q ? txByte_q[3'h7 - bitCnt_q] : 1'b0;
    end
  end

  // Register snapshot taken over by toggle handshake
  logic snapReq_q;
  srap_bank_t snapBank_q;
  always_ff @(posedge serialClock or negedge reset_n) begin
    if (!reset_n) begin
      snapMeta_q <= 1'b0;
      snapSync_q <= 1'b0;
      snapSeen_q <= 1'b0;
      snapAck_q <= 1'b0;
      linkBank_q <= BANK_RESET;
    end else begin
      snapMeta_q <= snapReq_q;
      snapSync_q <= snapMeta_q;
      snapSeen_q <= snapSync_q;
      if (snapSync_q != snapSeen_q) begin
        linkBank_q <= snapBank_q;
        snapAck_q <= snapSync_q;
      end
    end
  end

  // ---------------- System domain: writes and bank ----------------
  logic [2:0] wrSync_q;
  logic wrPend_q;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  srap_wr_word_t fifoOut;
  logic [1:0] ackSync_q;
  logic snapBusy;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrSync_q <= '0;
      wrPend_q <= 1'b0;
    end else begin
      wrSync_q <= {wrSync_q[1:0], wrReq_q};
      // New word waits here while the FIFO is full
      if (wrSync_q[2] != wrSync_q[1]) begin
        wrPend_q <= 1'b1;
      end else if (fifoInReady) begin
        wrPend_q <= 1'b0;
      end
    end
  end

  srap_fifo #(.WIDTH($bits(srap_wr_word_t)), .DEPTH(DEPTH)) writeFifo (
    .clock(clock),
    .reset_n(reset_n),
    .inData(wrWord_q),
    .inValid(wrPend_q),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // Bank frozen while a snapshot is in flight, so the copy stays coherent
  assign snapBusy = (snapReq_q != ackSync_q[1]);
  assign fifoOutReady = !snapBusy;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : gBank
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          regs[gi] <= BANK_RESET[gi];
        end else if (fifoOutValid && fifoOutReady && fifoOut.addr == ADDR_W'(gi)
                     // Standby writes only reach the enable bit
                     && (regs[OFS_DEVICE_ENABLE[2:0]][POS_CHIP_EN] || gi == 0)) begin
          regs[gi] <= fifoOut.data & BANK_MASK[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ackSync_q <= '0;
      snapReq_q <= 1'b0;
      snapBank_q <= BANK_RESET;
      chipEnable <= 1'b0;
    end else begin
      ackSync_q <= {ackSync_q[0], snapAck_q};
      chipEnable <= regs[OFS_DEVICE_ENABLE[2:0]][POS_CHIP_EN];
      if (!snapBusy && snapBank_q != regs) begin
        snapBank_q <= regs;
        snapReq_q <= !snapReq_q;
      end
    end
  end
endmodule // srap_port

`default_nettype wire

// File: srap_pkg.sv
// Constants and types of the serial register access port
`default_nettype none
package srap_pkg;
  localparam int NUM_REGS = 5;
  localparam int ADDR_W = 10;
  localparam int BYTE_W = 8;
  // Register offsets
  localparam logic [9:0] OFS_DEVICE_ENABLE = 10'h000;
  localparam logic [9:0] OFS_INITIAL_SETUP = 10'h001;
  localparam logic [9:0] OFS_SETUP_A = 10'h002;
  localparam logic [9:0] OFS_SETUP_B = 10'h003;
  localparam logic [9:0] OFS_SETUP_C = 10'h004;
  // Reset values
  localparam logic [7:0] RST_DEVICE_ENABLE = 8'h00;
  localparam logic [7:0] RST_INITIAL_SETUP = 8'h5e;
  localparam logic [7:0] RST_SETUP_A = 8'h00;
  localparam logic [7:0] RST_SETUP_B = 8'h00;
  localparam logic [7:0] RST_SETUP_C = 8'h47;
  // Writable bits; the enable register holds a single bit
  localparam logic [7:0] MASK_DEVICE_ENABLE = 8'h01;
  localparam int POS_CHIP_EN = 0;
  // Second address byte layout
  localparam int POS_ADDR_LOW_HI = 7;
  localparam int POS_ADDR_LOW_LO = 6;
  localparam int POS_DIR = 5;
  // Byte phase within one transfer
  typedef enum logic [1:0] {PH_ADDR_HIGH, PH_ADDR_LOW, PH_DATA} srap_phase_t;
  localparam int FIFO_DEPTH = 8;

  typedef logic [NUM_REGS-1:0][BYTE_W-1:0] srap_bank_t;
  localparam srap_bank_t BANK_RESET = {RST_SETUP_C, RST_SETUP_B, RST_SETUP_A, RST_INITIAL_SETUP, RST_DEVICE_ENABLE};
  localparam srap_bank_t BANK_MASK = {8'hff, 8'hff, 8'hff, 8'hff, MASK_DEVICE_ENABLE};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } srap_wr_word_t;

  typedef struct packed {
    logic spiMode;
    logic [1:0] followerAddrLow;
  } srap_strap_t;
endpackage
`default_nettype wire

// File: srap_port_properties.sv
// Concurrent checks on the serial register access port
`timescale 1ns/10ps
`default_nettype none
module srap_port_checker
  import srap_pkg::*;
#(parameter int DEPTH = FIFO_DEPTH) (
  input wire logic clock, // Clock
  input wire logic reset_n, // Reset
  input wire logic serialClock, // Link clock
  input wire logic selectN, // Select
  input wire logic dataIn, // Host bit
  input wire logic dataOut, // Device bit
  input wire logic dataOutOe, // Drive on
  input wire logic interface_select_strap, // Mode pin
  input wire logic address_strap_low, // Addr pin 0
  input wire logic address_strap_high, // Addr pin 1
  input wire srap_bank_t regs, // Registers
  input wire logic chipEnable, // Active
  input wire srap_strap_t strapState // Straps
);
  logic [5:0] cnt;
  logic wrDir;
  wire logic off = !reset_n || selectN;
  // Edge count saturates so long bursts never wrap
  always_ff @(posedge serialClock or posedge selectN or negedge reset_n) begin
    if (!reset_n || selectN) begin
      cnt <= 6'h00;
      wrDir <= 1'b0;
    end else begin
      cnt <= cnt + {5'h00, cnt != 6'h3f};
      wrDir <= (cnt == 6'h0a) ? dataIn : wrDir;
    end
  end
  property p_oe_idle; @(posedge clock) disable iff (!reset_n) selectN |-> !dataOutOe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive while idle");
  property p_oe_wr; @(posedge serialClock) disable iff (off) wrDir && cnt > 6'h0a |-> !dataOutOe; endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("drive in write");
  property p_oe_rd; @(posedge serialClock) disable iff (off) strapState.spiMode && !wrDir && cnt > 6'h0f |-> dataOutOe;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("no drive in read");
  property p_oe_early; @(posedge serialClock) disable iff (off) cnt < 6'h10 |-> !dataOutOe; endproperty
  a_oe_early: assert property (p_oe_early) else $error("drive in address");
  // Sampled clock is still high when the change lands on a falling edge
  property p_edge; @(dataOut) disable iff (off) dataOutOe |-> serialClock; endproperty
  a_edge: assert property (p_edge) else $error("data moved on rise");
  property p_mask; @(posedge clock) disable iff (!reset_n) regs[0][7:1] == 7'h00; endproperty
  a_mask: assert property (p_mask) else $error("enable spare bits set");
  property p_standby; @(posedge clock) disable iff (!reset_n) !chipEnable && !$past(chipEnable) |-> $stable(regs[4:1]);
  endproperty
  a_standby: assert property (p_standby) else $error("write in standby");
  property p_strap; @(posedge clock) disable iff (!reset_n) $past(reset_n, 3) |-> strapState ==
    {$past(interface_select_strap, 3), $past(address_strap_high, 3), $past(address_strap_low, 3)}; endproperty
  a_strap: assert property (p_strap) else $error("strap capture");
  c_read: cover property (@(posedge serialClock) dataOutOe);
  c_write: cover property (@(posedge serialClock) wrDir && cnt == 6'h18);
  c_standby: cover property (@(posedge clock) !chipEnable && !selectN);
endmodule // srap_port_checker
bind srap_port srap_port_checker #(.DEPTH(DEPTH)) u_chk (.clock, .reset_n, .serialClock, .selectN, .dataIn,
  .dataOut, .dataOutOe, .interface_select_strap, .address_strap_low, .address_strap_high, .regs, .chipEnable,
  .strapState);
`default_nettype wire

// File: srap_host.sv
// Host serial controller model
`timescale 1ns/10ps
`default_nettype none
module srap_host (
  output logic serialClock, // Link clock
  output logic selectN, // Select
  output logic dataIn, // Host bit
  input wire logic serialIn // Device bit
);
  initial {serialClock, selectN, dataIn} = 3'b010;
  // Edges with select high let the link settle
  task automatic wake(input int n);
    repeat (n) #24 serialClock = ~serialClock;
  endtask
  task automatic frame(input logic [9:0] a, input logic w, input logic [39:0] wd, input int nb,
    output logic [39:0] rd);
    logic [55:0] bits;
    bits = {a, w, 5'h15, wd};
    rd = '0;
    selectN <= 1'b0;
    for (int i = 0; i < 16 + nb; i++) begin
      dataIn <= bits[55-i];
      #24 serialClock = 1'b1;
      if (i >= 16) rd = {rd[38:0], serialIn};
      #24 serialClock = 1'b0;
    end
    #24 selectN <= 1'b1;
    // Released line, not last bit
    dataIn <= ~dataIn;
    wake(2);
  endtask
endmodule // srap_host
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the serial register access port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import srap_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b1;
  logic addrLow = 1'b0;
  logic addrHigh = 1'b1;
  wire logic sck, selN, sdi, dataOut, dataOutOe, chipEnable;
  wire logic dataLine = dataOutOe ? dataOut : 1'bz;
  srap_bank_t regs;
  srap_strap_t strapState;
  logic [39:0] got;
  int num_errors = 0;
  int cmp_count = 0;
  srap_host u_srap_host (.serialClock(sck), .selectN(selN), .dataIn(sdi), .serialIn(dataLine));
  srap_port u_srap_port (.clock, .reset_n, .serialClock(sck), .selectN(selN), .dataIn(sdi), .dataOut,
    .dataOutOe, .interface_select_strap(strap), .address_strap_low(addrLow), .address_strap_high(addrHigh),
    .regs, .chipEnable, .strapState);
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [39:0] d, input int nb);
    u_srap_host.frame(a, 1'b1, d, nb, got);
    // Word must cross domains before readback
    repeat (12) @(posedge clock);
  endtask
  task automatic rd(input logic [9:0] a, input int n, input logic [39:0] exp);
    u_srap_host.frame(a, 1'b0, 40'h0, 8 * n, got);
    check(got, exp);
  endtask
  task automatic restart();
    @(posedge clock) reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    u_srap_host.wake(4);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
  initial begin
    restart();
    check(regs, 40'h47_00_00_5e_00);
    check(40'(strapState), 40'h6);
    rd(10'h000, 5, 40'h00_00_00_00_00);
    wr(10'h002, 40'ha5_00_00_00_00, 8);
    check(regs, 40'h47_00_00_5e_00);
    rd(10'h002, 1, 40'h00);
    wr(10'h000, 40'hff_00_00_00_00, 8);
    check(40'(chipEnable), 40'h1);
    wr(10'h001, 40'ha5_3c_c3_96_00, 32);
    check(regs, 40'h96_c3_3c_a5_01);
    rd(10'h000, 5, 40'h01_a5_3c_c3_96);
    rd(10'h003, 2, 40'hc3_96);
    wr(10'h004, 40'h5a_77_00_00_00, 16);
    rd(10'h004, 2, 40'h5a_00);
    wr(10'h102, 40'h11_00_00_00_00, 8);
    wr(10'h003, 40'h22_00_00_00_00, 5);
    check(regs, 40'h5a_c3_3c_a5_01);
    strap <= 1'b0;
    addrLow <= 1'b1;
    addrHigh <= 1'b0;
    repeat (6) @(posedge clock);
    check(40'(strapState), 40'h1);
    // Let the link see the new mode before the frame
    u_srap_host.wake(4);
    wr(10'h001, 40'h33_00_00_00_00, 8);
    check(40'(regs[1]), 40'ha5);
    strap <= 1'b1;
    repeat (6) @(posedge clock);
    u_srap_host.wake(4);
    rd(10'h001, 1, 40'ha5);
    restart();
    check(regs, 40'h47_00_00_5e_00);
    rd(10'h000, 2, 40'h00_00);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
